// >>> rtl/sps_sequencer.sv
// Purpose: Attach, power-up, voltage change and hard reset retry timing
// Assumes: Inputs are clean levels synchronous to clk_sys
// Notes: Fast trips act one clock after the cause; retries keep cadence
// Operation
// - Debounce attach 185 ms before indicator low
// - Change supply selects 30 ms after accept
// - Supply fault: hard reset every 1395 ms
// - VBUS short: hard reset every 985 ms
// - Supply fault: hard reset 600 ms after attach
// - Silent sink: gate on 4.8 s, then reset
// - Logic rail high within 5 ms of attach
// - Gate disable low kills gate within 5 us
// - Fast overvoltage kills gate within 30 us
// - Large overcurrent kills gate within 30 us
// - Thermal trip stops discharge within 10 us
// - Plug supply on within 2 ms of indicator
// - Gate full drive within 2 ms of indicator
// - Slow voltage guards off during voltage transitions
// - Arm undervoltage, overcurrent guards 190 ms after gate
// - Power ready sent 260 ms after select change
// - Gate off 30 ms after hard reset
// - Hold VBUS low 765 ms after hard reset
`timescale 1ns/10ps
module sps_sequencer #(
  parameter int unsigned P_DEB = sps_pkg::DEB_CYC,
  parameter int unsigned P_ST = sps_pkg::ST_CYC,
  parameter int unsigned P_FLT = sps_pkg::FLT_CYC,
  parameter int unsigned P_SH = sps_pkg::SH_CYC,
  parameter int unsigned P_ON = sps_pkg::ON_CYC,
  parameter int unsigned P_NORESP = sps_pkg::NORESP_CYC,
  parameter int unsigned P_VP = sps_pkg::VP_CYC,
  parameter int unsigned P_STL = sps_pkg::STL_CYC,
  parameter int unsigned P_HR = sps_pkg::HR_CYC,
  parameter int unsigned P_SR = sps_pkg::SR_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic attach_det,
  input wire logic accessory_det,
  input wire logic power_input,
  input wire logic gate_disable_n,
  input wire logic vbus_short,
  input wire logic vbus_fast_ov,
  input wire logic oc_fast,
  input wire logic first_thermal_trip,
  input wire logic sink_comm,
  input wire logic request_accepted,
  input wire logic [1:0] request_sel,
  output logic port_attached_n,
  output logic accessory_n_a,
  output logic logic_rail_out,
  output logic plug_supply,
  output logic main_path_gate,
  output logic supply_select_1,
  output logic supply_select_2,
  output logic hard_reset_tx,
  output logic power_ready_tx,
  output logic slow_overvoltage_guard,
  output logic undervoltage_guard,
  output logic oc_guard,
  output logic discharge_output
);
  localparam int W = sps_pkg::CNT_W;
  localparam int GDOFF_LIM = sps_pkg::GDOFF_CYC;
  localparam int FOVP_LIM = sps_pkg::FOVP_CYC;
  localparam int OCP_LIM = sps_pkg::OCP_CYC;
  localparam int TJ1_LIM = sps_pkg::TJ1_CYC;

  sps_pkg::sps_regs_s r_reg;
  sps_pkg::sps_regs_s r_next;
  logic fault;
  logic [W-1:0] rt_lim;
  logic gate_want;

  // True on the last cycle of a span of lim cycles
  function automatic logic hit(input logic [W-1:0] c,
                               input int unsigned lim);
    hit = (c >= W'(lim - 1));
  endfunction

  // Supply fault means gate disabled or no power input
  assign fault = !gate_disable_n || !power_input;

  // Retry span: first fault reset is short, then the steady cadence
  always_comb begin
    if (fault) begin
      rt_lim = r_reg.first_done ? W'(P_FLT) : W'(P_ON);
    end else if (vbus_short) begin
      rt_lim = W'(P_SH);
    end else begin
      rt_lim = W'(P_NORESP);
    end
  end

  // Next state of the whole sequencer
  always_comb begin
    r_next = r_reg;
    r_next.hr = 1'b0;
    r_next.psr = 1'b0;
    unique case (r_reg.state)
      sps_pkg::SPS_IDLE: begin
        if (attach_det) begin
          r_next.state = sps_pkg::SPS_DEB;
          r_next.tmr = '0;
          r_next.rail = 1'b1;
        end
      end
      sps_pkg::SPS_DEB: begin
        r_next.tmr = r_reg.tmr + 1'b1;
        if (hit(r_reg.tmr, P_DEB)) begin
          r_next.state = sps_pkg::SPS_ON;
          r_next.tmr = '0;
          r_next.rt = '0;
          r_next.first_done = 1'b0;
          r_next.att_n = 1'b0;
          r_next.acc_n = !accessory_det;
          r_next.plug = 1'b1;
        end
      end
      sps_pkg::SPS_ON: begin
        // Traffic from a healthy sink restarts the no-response wait
        r_next.rt = r_reg.rt + 1'b1;
        if (!fault && !vbus_short && sink_comm) begin
          r_next.rt = '0;
        end
        // Voltage change: selects after the transition wait, then settle
        unique case (r_reg.tr_ph)
          sps_pkg::PH_IDLE: begin
            if (request_accepted) begin
              r_next.tr_ph = sps_pkg::PH_WAIT_SEL;
              r_next.tr = '0;
            end
          end
          sps_pkg::PH_WAIT_SEL: begin
            r_next.tr = r_reg.tr + 1'b1;
            if (hit(r_reg.tr, P_ST)) begin
              r_next.sel = request_sel;
              r_next.tr_ph = sps_pkg::PH_SETTLE;
              r_next.tr = '0;
            end
          end
          sps_pkg::PH_SETTLE: begin
            r_next.tr = r_reg.tr + 1'b1;
            if (hit(r_reg.tr, P_STL)) begin
              r_next.psr = 1'b1;
              r_next.tr_ph = sps_pkg::PH_IDLE;
            end
          end
          default: begin
            r_next.tr_ph = sps_pkg::PH_IDLE;
          end
        endcase
        // Retry timer expiry sends a hard reset; cadence runs from here
        if (r_reg.rt >= rt_lim - 1'b1) begin
          r_next.state = sps_pkg::SPS_HRST;
          r_next.hr = 1'b1;
          r_next.rt = '0;
          r_next.tmr = '0;
          r_next.first_done = 1'b1;
          r_next.tr_ph = sps_pkg::PH_IDLE;
          r_next.sel = 2'h0;
          r_next.trip = 1'b0;
        end
      end
      sps_pkg::SPS_HRST: begin
        // Gate stays on until the reset hold ends
        r_next.rt = r_reg.rt + 1'b1;
        r_next.tmr = r_reg.tmr + 1'b1;
        if (hit(r_reg.tmr, P_HR)) begin
          r_next.state = sps_pkg::SPS_RECOV;
          r_next.tmr = '0;
        end
      end
      sps_pkg::SPS_RECOV: begin
        r_next.rt = r_reg.rt + 1'b1;
        r_next.tmr = r_reg.tmr + 1'b1;
        if (hit(r_reg.tmr, P_SR)) begin
          r_next.state = sps_pkg::SPS_ON;
          r_next.tmr = '0;
        end
      end
      default: begin
        r_next = sps_pkg::RST_REGS;
      end
    endcase

    // Fast trips latch until the next hard reset; set beats clear
    if (vbus_fast_ov || oc_fast) begin
      r_next.trip = 1'b1;
    end

    // Gate follows state and is killed by any fast fault at once
    gate_want = (r_next.state == sps_pkg::SPS_ON) ||
                (r_next.state == sps_pkg::SPS_HRST);
    r_next.gate = gate_want && gate_disable_n && !vbus_fast_ov &&
                  !oc_fast && !r_next.trip;

    // Protection arms only after the gate has been on long enough
    if (r_reg.gate) begin
      if (!r_reg.armed) begin
        r_next.arm = r_reg.arm + 1'b1;
      end
      if (hit(r_reg.arm, P_VP)) begin
        r_next.armed = 1'b1;
      end
    end else begin
      r_next.arm = '0;
      r_next.armed = 1'b0;
    end
    r_next.ocg = r_next.armed;
    // Slow guards would trip on a legal voltage ramp, so hold them off
    r_next.sovg = r_next.armed && (r_next.tr_ph == sps_pkg::PH_IDLE)
                  && (r_next.state == sps_pkg::SPS_ON);
    r_next.uvg = r_next.armed && (r_next.tr_ph == sps_pkg::PH_IDLE)
                 && (r_next.state == sps_pkg::SPS_ON);

    // Discharge pulls VBUS low in recovery unless the die is hot
    r_next.dsc = (r_next.state == sps_pkg::SPS_RECOV) &&
                 !first_thermal_trip;

    // Detach overrides everything and clears every timer
    if (!attach_det && r_reg.state != sps_pkg::SPS_IDLE) begin
      r_next = sps_pkg::RST_REGS;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r_reg <= sps_pkg::RST_REGS;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from the state register
  assign port_attached_n = r_reg.att_n;
  assign accessory_n_a = r_reg.acc_n;
  assign logic_rail_out = r_reg.rail;
  assign plug_supply = r_reg.plug;
  assign main_path_gate = r_reg.gate;
  assign supply_select_1 = r_reg.sel[0];
  assign supply_select_2 = r_reg.sel[1];
  assign hard_reset_tx = r_reg.hr;
  assign power_ready_tx = r_reg.psr;
  assign slow_overvoltage_guard = r_reg.sovg;
  assign undervoltage_guard = r_reg.uvg;
  assign oc_guard = r_reg.ocg;
  assign discharge_output = r_reg.dsc;

  // Checks on timing and safety relations
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_attached;
    attach_det [*2];
  endsequence

  sequence s_debounced;
    $fell(port_attached_n);
  endsequence

  property p_deb_len;
    s_debounced |-> $past(r_reg.tmr) == W'(P_DEB - 1);
  endproperty
  a_deb_len: assert property (p_deb_len)
    else $error("indicator fell before debounce ended");

  property p_rail;
    ($rose(attach_det) && r_reg.state == sps_pkg::SPS_IDLE) ##1
      attach_det |-> logic_rail_out;
  endproperty
  a_rail: assert property (p_rail)
    else $error("logic rail not raised after attach");

  property p_gdoff;
    (!gate_disable_n) [*2] |-> ##[0:GDOFF_LIM] !main_path_gate;
  endproperty
  a_gdoff: assert property (p_gdoff)
    else $error("gate still on with gate disable low");

  property p_fovp;
    vbus_fast_ov |-> ##[1:FOVP_LIM] !main_path_gate;
  endproperty
  a_fovp: assert property (p_fovp)
    else $error("gate still on after fast overvoltage");

  property p_ocp;
    oc_fast |-> ##[1:OCP_LIM] !main_path_gate;
  endproperty
  a_ocp: assert property (p_ocp)
    else $error("gate still on after overcurrent");

  property p_tj1;
    first_thermal_trip |-> ##[1:TJ1_LIM] !discharge_output;
  endproperty
  a_tj1: assert property (p_tj1)
    else $error("discharge running above thermal trip");

  property p_plug;
    s_debounced |-> plug_supply;
  endproperty
  a_plug: assert property (p_plug)
    else $error("plug supply off after indicator low");

  property p_gate_on;
    s_debounced ##0 (gate_disable_n && power_input && !vbus_fast_ov &&
      !oc_fast) |-> ##1 (main_path_gate || !attach_det || r_reg.trip);
  endproperty
  a_gate_on: assert property (p_gate_on)
    else $error("gate not driven after indicator low");

  property p_transit;
    (r_reg.tr_ph != sps_pkg::PH_IDLE) |->
      !slow_overvoltage_guard && !undervoltage_guard;
  endproperty
  a_transit: assert property (p_transit)
    else $error("slow guards active during transition");

  property p_arm;
    $rose(oc_guard) |-> $past(r_reg.arm) == W'(P_VP - 1);
  endproperty
  a_arm: assert property (p_arm)
    else $error("guards armed at wrong time");

  // One-cycle pulse; the hold state follows unless the sink left
  property p_hr_pulse;
    hard_reset_tx |=> !hard_reset_tx &&
      (r_reg.state == sps_pkg::SPS_HRST || port_attached_n);
  endproperty
  a_hr_pulse: assert property (p_hr_pulse)
    else $error("hard reset pulse malformed");

  property p_detach;
    s_attached ##1 !attach_det |=> port_attached_n && !main_path_gate &&
      !logic_rail_out && r_reg.rt == '0;
  endproperty
  a_detach: assert property (p_detach)
    else $error("detach did not clear sequencer");
endmodule

// >>> common/sps_pkg.sv
// Purpose: Shared constants and types for the source port power sequencer
// Assumes: System clock of 25 MHz; all times are exact multiples of it
// Notes: Long counts become top-level parameters so benches can shrink them
package sps_pkg;
  // Clock rate in kHz, cycles per millisecond
  localparam int CLK_KHZ = 25000;
  localparam int CNT_W = 27;

  // Sequencing times in ms, as specified
  localparam int DEB_MS = 185;
  localparam int ST_MS = 30;
  localparam int FLT_MS = 1395;
  localparam int SH_MS = 985;
  localparam int ON_MS = 600;
  localparam int NORESP_MS = 4800;
  localparam int RAIL_MS = 5;
  localparam int VCON_MS = 2;
  localparam int VP_MS = 190;
  localparam int STL_MS = 260;
  localparam int HR_MS = 30;
  localparam int SR_MS = 765;

  // Fast reaction limits in us
  localparam int GDOFF_US = 5;
  localparam int FOVP_US = 30;
  localparam int OCP_US = 30;
  localparam int TJ1_US = 10;

  // Cycle counts; microsecond times round down, exact here at 25 MHz
  localparam int DEB_CYC = DEB_MS * CLK_KHZ;
  localparam int ST_CYC = ST_MS * CLK_KHZ;
  localparam int FLT_CYC = FLT_MS * CLK_KHZ;
  localparam int SH_CYC = SH_MS * CLK_KHZ;
  localparam int ON_CYC = ON_MS * CLK_KHZ;
  localparam int NORESP_CYC = NORESP_MS * CLK_KHZ;
  localparam int RAIL_CYC = RAIL_MS * CLK_KHZ;
  localparam int VCON_CYC = VCON_MS * CLK_KHZ;
  localparam int VP_CYC = VP_MS * CLK_KHZ;
  localparam int STL_CYC = STL_MS * CLK_KHZ;
  localparam int HR_CYC = HR_MS * CLK_KHZ;
  localparam int SR_CYC = SR_MS * CLK_KHZ;
  localparam int GDOFF_CYC = GDOFF_US * CLK_KHZ / 1000;
  localparam int FOVP_CYC = FOVP_US * CLK_KHZ / 1000;
  localparam int OCP_CYC = OCP_US * CLK_KHZ / 1000;
  localparam int TJ1_CYC = TJ1_US * CLK_KHZ / 1000;

  // Transition phases of a voltage change
  localparam logic [1:0] PH_IDLE = 2'h0;
  localparam logic [1:0] PH_WAIT_SEL = 2'h1;
  localparam logic [1:0] PH_SETTLE = 2'h2;

  // Sequencer states, Gray along attach, run, reset, recover
  typedef enum logic [2:0] {
    SPS_IDLE = 3'h0,
    SPS_DEB = 3'h1,
    SPS_ON = 3'h3,
    SPS_HRST = 3'h2,
    SPS_RECOV = 3'h6
  } sps_state_e;

  typedef struct packed {
    sps_state_e state;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] rt;
    logic [CNT_W-1:0] tr;
    logic [CNT_W-1:0] arm;
    logic [1:0] tr_ph;
    logic first_done;
    logic armed;
    logic trip;
    logic [1:0] sel;
    logic att_n;
    logic acc_n;
    logic rail;
    logic plug;
    logic gate;
    logic hr;
    logic psr;
    logic sovg;
    logic uvg;
    logic ocg;
    logic dsc;
  } sps_regs_s;

  // Idle values; indicators are active low so they rest high
  localparam sps_regs_s RST_REGS = '{
    state: SPS_IDLE, tmr: '0, rt: '0, tr: '0, arm: '0, tr_ph: PH_IDLE,
    first_done: 1'b0, armed: 1'b0, trip: 1'b0, sel: 2'h0,
    att_n: 1'b1, acc_n: 1'b1, rail: 1'b0, plug: 1'b0, gate: 1'b0,
    hr: 1'b0, psr: 1'b0, sovg: 1'b0, uvg: 1'b0, ocg: 1'b0, dsc: 1'b0};
endpackage

// >>> tb/sps_sink_model.sv
// Purpose: Behavioural sink on the far side of the sequencer
// Assumes: The bench calls its tasks; it drives at falling edges
// Notes: Select value held until the next accept, as it is sampled late
`timescale 1ns/10ps
module sps_sink_model (
  input wire logic clk_sys,
  output logic attach_det,
  output logic accessory_det,
  output logic sink_comm,
  output logic request_accepted,
  output logic [1:0] request_sel
);
  // Detached and silent at time zero
  initial begin
    attach_det = 1'b0;
    accessory_det = 1'b0;
    sink_comm = 1'b0;
    request_accepted = 1'b0;
    request_sel = 2'h0;
  end

  // Attach or detach the CC level
  task automatic plug(input logic on, input logic acc = 1'b0);
    @(negedge clk_sys);
    attach_det = on;
    accessory_det = acc;
  endtask

  // One-cycle accept; select must outlive the pulse
  task automatic accept(input logic [1:0] sel);
    @(negedge clk_sys);
    request_accepted = 1'b1;
    request_sel = sel;
    @(negedge clk_sys);
    request_accepted = 1'b0;
  endtask

  // One pulse of valid traffic
  task automatic talk();
    @(negedge clk_sys);
    sink_comm = 1'b1;
    @(negedge clk_sys);
    sink_comm = 1'b0;
  endtask
endmodule

// >>> tb/source_port_power_sequencer_test.sv
// Purpose: Self-checking bench for the source port power sequencer
// Assumes: Shortened timing parameters; inputs change at falling edges
// Notes: Counts are edges after the stimulus, settled 1 ns past the edge
`timescale 1ns/10ps
module source_port_power_sequencer_test;
  // Shortened spans; retry spans exceed hard reset plus recovery
  localparam int DEB = 20;
  localparam int ST = 10;
  localparam int FLT = 150;
  localparam int SH = 120;
  localparam int ON = 60;
  localparam int NR = 200;
  localparam int VP = 15;
  localparam int STL = 12;
  localparam int HR = 8;
  localparam int SR = 20;
  localparam logic [12:0] IDLE = 13'h1800;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic power_input = 1'b1;
  logic gate_disable_n = 1'b1;
  logic vbus_short = 1'b0;
  logic vbus_fast_ov = 1'b0;
  logic oc_fast = 1'b0;
  logic first_thermal_trip = 1'b0;
  logic attach_det, accessory_det, sink_comm, request_accepted;
  logic [1:0] request_sel;
  logic port_attached_n, accessory_n_a, logic_rail_out, plug_supply;
  logic main_path_gate, supply_select_1, supply_select_2, hard_reset_tx;
  logic power_ready_tx, slow_overvoltage_guard, undervoltage_guard;
  logic oc_guard, discharge_output;
  logic [12:0] outs;
  int err_count = 0;
  int n_compared = 0;
  int n;

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  // All outputs in one vector for rest-state checks
  assign outs = {port_attached_n, accessory_n_a, logic_rail_out,
    plug_supply, main_path_gate, supply_select_1, supply_select_2,
    hard_reset_tx, power_ready_tx, slow_overvoltage_guard,
    undervoltage_guard, oc_guard, discharge_output};

  sps_sequencer #(.P_DEB(DEB), .P_ST(ST), .P_FLT(FLT), .P_SH(SH),
    .P_ON(ON), .P_NORESP(NR), .P_VP(VP), .P_STL(STL), .P_HR(HR),
    .P_SR(SR)) dut_u (.clk_sys, .rstn, .attach_det, .accessory_det,
    .power_input, .gate_disable_n, .vbus_short, .vbus_fast_ov, .oc_fast,
    .first_thermal_trip, .sink_comm, .request_accepted, .request_sel,
    .port_attached_n, .accessory_n_a, .logic_rail_out, .plug_supply,
    .main_path_gate, .supply_select_1, .supply_select_2, .hard_reset_tx,
    .power_ready_tx, .slow_overvoltage_guard, .undervoltage_guard,
    .oc_guard, .discharge_output);

  sps_sink_model sink_u (.clk_sys, .attach_det, .accessory_det,
    .sink_comm, .request_accepted, .request_sel);

  // Pick one watched output by index
  function automatic logic sig(input int k);
    case (k)
      0: return port_attached_n;
      1: return logic_rail_out;
      3: return main_path_gate;
      4: return hard_reset_tx;
      5: return power_ready_tx;
      7: return supply_select_2;
      8: return discharge_output;
      default: return oc_guard;
    endcase
  endfunction

  // Count edges until output k shows v; bounded so a hang cannot stall
  task automatic wait_sig(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Attach, then rail, indicator, plug supply and gate timing
  task automatic attach(input logic gate_exp, input logic acc = 1'b0);
    sink_u.plug(1'b1, acc);
    wait_sig(1, 1'b1, 9);
    chk(n, 1);
    wait_sig(0, 1'b0, DEB + 9);
    chk(n, DEB);
    chk(accessory_n_a, !acc);
    chk(plug_supply, 1'b1);
    chk(main_path_gate, gate_exp);
  endtask

  // Detach, clear faults, expect every output at rest next edge
  task automatic detach();
    sink_u.plug(1'b0);
    power_input = 1'b1;
    gate_disable_n = 1'b1;
    vbus_short = 1'b0;
    vbus_fast_ov = 1'b0;
    oc_fast = 1'b0;
    first_thermal_trip = 1'b0;
    @(posedge clk_sys);
    #1;
    chk(outs, IDLE);
  endtask

  // Aborted debounce, guard arming, voltage change
  task automatic t_run();
    sink_u.plug(1'b1);
    repeat (5) @(posedge clk_sys);
    detach();
    attach(1'b1);
    wait_sig(9, 1'b1, VP + 9);
    chk(n, VP);
    chk(undervoltage_guard, 1'b1);
    sink_u.accept(2'b10);
    chk(slow_overvoltage_guard, 1'b0);
    chk(undervoltage_guard, 1'b0);
    wait_sig(7, 1'b1, ST + 9);
    chk(n, ST);
    chk(supply_select_1, 1'b0);
    wait_sig(5, 1'b1, STL + 9);
    chk(n, STL);
    detach();
  endtask

  // Traffic holds off retries; silence gives reset, then recovery
  task automatic t_silent();
    attach(1'b1);
    repeat (2) begin
      wait_sig(4, 1'b1, NR - 20);
      chk(n, NR - 20);
      sink_u.talk();
    end
    wait_sig(4, 1'b1, NR + 9);
    chk(n, NR);
    chk(main_path_gate, 1'b1);
    wait_sig(3, 1'b0, HR + 9);
    chk(n, HR);
    chk(discharge_output, 1'b1);
    wait_sig(3, 1'b1, SR + 9);
    chk(n, SR);
    detach();
  endtask

  // Supply absent or gated off: first retry, then steady cadence
  task automatic t_fault(input int kind);
    @(negedge clk_sys);
    power_input = (kind != 0);
    gate_disable_n = (kind == 0);
    // Missing power only paces retries; gate disable kills the gate
    attach(kind == 0);
    wait_sig(4, 1'b1, ON + 9);
    chk(n, ON);
    @(posedge clk_sys);
    #1;
    wait_sig(4, 1'b1, FLT + 9);
    chk(n, FLT - 1);
    detach();
  endtask

  // Shorted VBUS cadence; thermal trip cuts discharge
  task automatic t_short();
    @(negedge clk_sys);
    vbus_short = 1'b1;
    attach(1'b1, 1'b1);
    wait_sig(4, 1'b1, SH + 9);
    @(posedge clk_sys);
    #1;
    wait_sig(4, 1'b1, SH + 9);
    chk(n, SH - 1);
    wait_sig(8, 1'b1, HR + 9);
    chk(discharge_output, 1'b1);
    @(negedge clk_sys);
    first_thermal_trip = 1'b1;
    @(posedge clk_sys);
    #1;
    chk(discharge_output, 1'b0);
    detach();
  endtask

  // Fast shutdown causes drop the gate on the next edge
  task automatic t_fast(input int kind);
    attach(1'b1);
    @(negedge clk_sys);
    case (kind)
      0: gate_disable_n = 1'b0;
      1: vbus_fast_ov = 1'b1;
      default: oc_fast = 1'b1;
    endcase
    wait_sig(3, 1'b0, sps_pkg::GDOFF_CYC);
    chk(n, 1);
    detach();
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    chk(outs, IDLE);
    @(negedge clk_sys);
    rstn = 1'b1;
    t_run();
    t_silent();
    for (int k = 0; k < 2; k++) t_fault(k);
    t_short();
    for (int k = 0; k < 3; k++) t_fast(k);
    end_sim();
  end

  // Watchdog, about thirteen times the expected run
  initial begin
    #(40 * 20000);
    err_count++;
    end_sim();
  end
endmodule
